// >>> sim/tb_converter_alarm_monitor.sv
/*
  tb_converter_alarm_monitor: self-checking bench for cam_top.
  assumes: cam_pkg and cam_top compiled first; one clock, apb register access.
*/
`timescale 1ns/1ps
module tb_converter_alarm_monitor;
  // ====================
  // stimulus and observed signals
  logic        clk     = 1'h0;
  logic        rst_n   = 1'h0;
  logic        psel    = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite  = 1'h0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pll_ok  = 1'h1;
  logic        link_ok = 1'h1;
  logic        realign = 1'h0;
  logic        sysref  = 1'h0;
  logic        ilas    = 1'h0;
  logic        pd_exit = 1'h0;
  logic        tick    = 1'h0;
  logic        bump    = 1'h0;
  logic [31:0] ph_a    = 32'h0;
  logic [31:0] ph_b    = 32'h0;
  logic [3:0]  ck_a    = 4'h5;
  logic [3:0]  ck_b    = 4'h5;
  logic        pin;
  logic        irq;
  logic [31:0] rd_v;
  logic        err_v;
  int          num_errors = 0;
  int          cmp_count  = 0;

  always #20 clk = ~clk;

  // accumulators advance together; bump flips one bit of b for a cycle
  always @(posedge clk) begin
    tick <= ~tick;
    ph_a <= ph_a + 32'h3;
    ph_b <= (ph_a + 32'h3) ^ {31'h0, bump};
  end

  cam_top u_cam_top (
    .clk_in(clk), .rst_n_in(rst_n),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr),
    .pll_locked_in(pll_ok), .link_data_state_in(link_ok),
    .realign_pulse_in(realign), .sysref_pulse_in(sysref),
    .ilas_start_in(ilas), .powerdown_exit_in(pd_exit),
    .phase_acc_a_in(ph_a), .phase_acc_b_in(ph_b),
    .half_rate_tick_in(tick), .clocks_a_in(ck_a), .clocks_b_in(ck_b),
    .calibration_status_pin_out(pin), .irq_out(irq)
  );

  // ====================
  // shared helpers
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask

  // entered just after a rising edge; holds the request until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) chk("pready", 32'h1, 32'h0);
    rd_v  = prdata;
    err_v = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'h0, a, 32'h0);
    chk(nm, exp, rd_v);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task pulse(input int k);
    case (k)
      0: pll_ok <= 1'h0;
      1: link_ok <= 1'h0;
      2: realign <= 1'h1;
      4: pd_exit <= 1'h1;
      default: bump <= 1'h1;
    endcase
    @(posedge clk);
    pll_ok  <= 1'h1;
    link_ok <= 1'h1;
    realign <= 1'h0;
    pd_exit <= 1'h0;
    bump    <= 1'h0;
    cyc(3);
  endtask

  // ====================
  // scenarios
  task t_reset;
    rd(cam_pkg::OFF_STATUS, 32'h0, "status rst");
    rd(cam_pkg::OFF_MASK, 32'h1f, "mask rst");
    rd(cam_pkg::OFF_SUMMARY, 32'h0, "summary rst");
    rd(cam_pkg::OFF_CONFIG, 32'h0, "config rst");
    rd(cam_pkg::OFF_IRQ_MASK, 32'h0, "irq mask rst");
    rd(cam_pkg::OFF_LIVE, 32'h1, "sync rst");
    rd(8'h18, 32'h0, "unmapped data");
    chk("unmapped err", 32'h1, {31'h0, err_v});
    rd(8'h02, 32'h0, "unaligned data");
    chk("unaligned err", 32'h1, {31'h0, err_v});
  endtask

  task t_src;
    for (int k = 0; k < 5; k++) begin
      if (k != 3) begin
        pulse(k);
        rd(cam_pkg::OFF_STATUS, 32'h1 << k, "status set");
        wr(cam_pkg::OFF_STATUS, 32'h0);
        rd(cam_pkg::OFF_STATUS, 32'h1 << k, "status kept");
        wr(cam_pkg::OFF_STATUS, 32'h1 << k);
        rd(cam_pkg::OFF_STATUS, 32'h0, "status clr");
      end
    end
  endtask

  task t_osc;
    pulse(3);
    rd(cam_pkg::OFF_STATUS, 32'h0, "osc unsynced");
    sysref <= 1'h1;
    cyc(1);
    sysref <= 1'h0;
    cyc(2);
    rd(cam_pkg::OFF_LIVE, 32'h2, "sync sysref");
    pulse(3);
    rd(cam_pkg::OFF_STATUS, 32'h8, "osc upset");
    wr(cam_pkg::OFF_CONFIG, 32'h2);
    pulse(4);
    wr(cam_pkg::OFF_STATUS, 32'h18);
    rd(cam_pkg::OFF_LIVE, 32'h1, "sync dropped");
    ilas <= 1'h1;
    cyc(1);
    ilas <= 1'h0;
    cyc(2);
    rd(cam_pkg::OFF_LIVE, 32'h2, "sync ilas");
    pulse(3);
    rd(cam_pkg::OFF_STATUS, 32'h8, "osc upset ilas");
    wr(cam_pkg::OFF_STATUS, 32'h8);
  endtask

  task t_clk;
    ck_b <= 4'ha;
    cyc(2);
    ck_b <= 4'h5;
    cyc(4);
    rd(cam_pkg::OFF_STATUS, 32'h10, "clk upset");
    wr(cam_pkg::OFF_STATUS, 32'h10);
  endtask

  task t_sum;
    pulse(0);
    rd(cam_pkg::OFF_SUMMARY, 32'h0, "summary masked");
    wr(cam_pkg::OFF_MASK, 32'h1e);
    rd(cam_pkg::OFF_SUMMARY, 32'h1, "summary set");
    chk("pin unselected", 32'h0, {31'h0, pin});
    wr(cam_pkg::OFF_CONFIG, 32'h1);
    cyc(2);
    chk("pin alarm", 32'h1, {31'h0, pin});
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(cam_pkg::OFF_IRQ_MASK, 32'h1);
    cyc(2);
    chk("irq set", 32'h1, {31'h0, irq});
    wr(cam_pkg::OFF_STATUS, 32'h1);
    cyc(2);
    chk("pin clr", 32'h0, {31'h0, pin});
    chk("irq clr", 32'h0, {31'h0, irq});
    pulse(2);
    rd(cam_pkg::OFF_SUMMARY, 32'h0, "summary other");
    chk("pin masked", 32'h0, {31'h0, pin});
  endtask

  // event held across the clearing write's access edge
  task t_race;
    realign <= 1'h1;
    wr(cam_pkg::OFF_STATUS, 32'h4);
    realign <= 1'h0;
    cyc(2);
    rd(cam_pkg::OFF_STATUS, 32'h4, "set beats clr");
    wr(cam_pkg::OFF_STATUS, 32'h4);
    rd(cam_pkg::OFF_STATUS, 32'h0, "race clr");
  endtask

  // ====================
  // verdict and sequencing
  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    t_reset;
    t_src;
    t_osc;
    t_clk;
    t_sum;
    t_race;
    test_done;
  end

  // tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    test_done;
  end
endmodule

// >>> src/cam_cmp.sv
/*
  cam_cmp: registered word comparator between channel a and channel b.
  assumes: both words are synchronous to clk_in.
*/
`timescale 1ns/1ps
module cam_cmp #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // words to compare
  input  wire logic [W-1:0] word_a_in,
  input  wire logic [W-1:0] word_b_in,
  // result
  output logic              differ_out
);

  // ==========================================================
  // registered compare keeps the long xor tree off the flag path
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      differ_out <= 1'b0;
    end else begin
      differ_out <= (word_a_in != word_b_in);
    end
  end

endmodule

// >>> src/cam_pkg.sv
/*
  cam_pkg: register map, field positions, reset values and state codes
  shared by the converter alarm monitor.
  assumes: a 32-bit apb slave, one aligned word per register.
*/
package cam_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFF_STATUS    = 8'h00;
  localparam logic [7:0] OFF_MASK      = 8'h04;
  localparam logic [7:0] OFF_SUMMARY   = 8'h08;
  localparam logic [7:0] OFF_CONFIG    = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h10;
  localparam logic [7:0] OFF_LIVE      = 8'h14;

  // ==========================================================
  // alarm bit positions within status, mask and irq mask
  localparam int ALM_PLL_UNLOCK   = 0;
  localparam int ALM_LINK_IDLE    = 1;
  localparam int ALM_REALIGN      = 2;
  localparam int ALM_OSC_UPSET    = 3;
  localparam int ALM_CLK_UPSET    = 4;
  localparam int ALM_W            = 5;

  // ==========================================================
  // config register fields
  localparam int CFG_PIN_ALARM    = 0;
  localparam int CFG_SYNC_ILAS    = 1;
  localparam int CFG_W            = 2;

  // ==========================================================
  // reset values
  localparam logic [ALM_W-1:0] STATUS_RST   = 5'h00;
  localparam logic [ALM_W-1:0] MASK_RST     = 5'h1f;
  localparam logic [ALM_W-1:0] IRQ_MASK_RST = 5'h00;
  localparam logic [CFG_W-1:0] CONFIG_RST   = 2'h0;

  // ==========================================================
  // widths
  localparam int PHASE_W = 32;
  localparam int CLKS_W  = 4;

  // ==========================================================
  // oscillator sync tracker states
  typedef enum logic [1:0] {
    CAM_OSC_UNSYNCED = 2'b01,
    CAM_OSC_SYNCED   = 2'b10
  } cam_osc_e;

endpackage

// >>> src/cam_top.sv
/*
  cam_top: alarm monitor for a dual-channel converter with serial link.
  holds sticky alarms, summary, status pin, interrupt and apb registers.
  assumes: all inputs synchronous to clk_in; link/pll status are levels.
*/
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
// Contract
// - five alarm sources are detected
// - each alarm sticky until host writes one
// - unmasked alarms appear in summary register
// - status pin high on unmasked alarm when selected
// - phase accumulator mismatch sets oscillator flag
// - oscillator detection valid only after sync
// - half-rate clock mismatch sets clock flag
// - powerdown exit may set clock flag
module cam_top (
  // clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        rst_n_in,
  // apb slave
  input  wire logic                        psel_in,
  input  wire logic                        penable_in,
  input  wire logic                        pwrite_in,
  input  wire logic [7:0]                  paddr_in,
  input  wire logic [31:0]                 pwdata_in,
  output logic      [31:0]                 prdata_out,
  output logic                             pready_out,
  output logic                             pslverr_out,
  // alarm sources and sync events
  input  wire logic                        pll_locked_in,
  input  wire logic                        link_data_state_in,
  input  wire logic                        realign_pulse_in,
  input  wire logic                        sysref_pulse_in,
  input  wire logic                        ilas_start_in,
  input  wire logic                        powerdown_exit_in,
  // channel comparison
  input  wire logic [cam_pkg::PHASE_W-1:0] phase_acc_a_in,
  input  wire logic [cam_pkg::PHASE_W-1:0] phase_acc_b_in,
  input  wire logic                        half_rate_tick_in,
  input  wire logic [cam_pkg::CLKS_W-1:0]  clocks_a_in,
  input  wire logic [cam_pkg::CLKS_W-1:0]  clocks_b_in,
  // outputs
  output logic                             calibration_status_pin_out,
  output logic                             irq_out
);

  // ==========================================================
  // state
  typedef cam_pkg::cam_osc_e cam_osc_state_t;

  logic [cam_pkg::ALM_W-1:0] alarm_status_bits_q;
  logic [cam_pkg::ALM_W-1:0] alarm_status_bits_d;
  logic [cam_pkg::ALM_W-1:0] alarm_mask_q;
  logic [cam_pkg::ALM_W-1:0] irq_mask_q;
  logic [cam_pkg::CFG_W-1:0] config_q;
  logic [cam_pkg::ALM_W-1:0] event_d;
  logic [cam_pkg::ALM_W-1:0] clear_d;
  logic                      summary_d;
  cam_osc_state_t            osc_q;
  logic                      osc_differ;
  logic                      clk_differ;
  logic                      clk_mismatch_q;
  logic                      wr_en;
  logic                      rd_en;
  logic                      sync_evt;

  assign wr_en = psel_in && penable_in && pwrite_in;
  assign rd_en = psel_in && !penable_in && !pwrite_in;

  // ==========================================================
  // comparators
  cam_cmp #(
    .W (cam_pkg::PHASE_W)
  ) u_osc_cmp (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .word_a_in  (phase_acc_a_in),
    .word_b_in  (phase_acc_b_in),
    .differ_out (osc_differ)
  );

  // clock groups sampled straight, only on half-rate ticks
  assign clk_differ = (clocks_a_in != clocks_b_in);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      clk_mismatch_q <= 1'b0;
    end else begin
      clk_mismatch_q <= half_rate_tick_in && clk_differ;
    end
  end

  // ==========================================================
  // oscillator sync tracker
  assign sync_evt = config_q[cam_pkg::CFG_SYNC_ILAS] ? ilas_start_in : sysref_pulse_in;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      osc_q <= cam_pkg::CAM_OSC_UNSYNCED;
    end else begin
      case (osc_q)
        cam_pkg::CAM_OSC_UNSYNCED: begin
          if (sync_evt) begin
            osc_q <= cam_pkg::CAM_OSC_SYNCED;
          end
        end
        cam_pkg::CAM_OSC_SYNCED: begin
          // powerdown loses sync; host must resync
          if (powerdown_exit_in) begin
            osc_q <= cam_pkg::CAM_OSC_UNSYNCED;
          end
        end
        default: begin
          osc_q <= cam_pkg::CAM_OSC_UNSYNCED;
        end
      endcase
    end
  end

  // ==========================================================
  // alarm events and sticky status
  always_comb begin
    event_d = '0;
    event_d[cam_pkg::ALM_PLL_UNLOCK] = !pll_locked_in;
    event_d[cam_pkg::ALM_LINK_IDLE]  = !link_data_state_in;
    event_d[cam_pkg::ALM_REALIGN]    = realign_pulse_in;
    event_d[cam_pkg::ALM_OSC_UPSET]  = osc_differ && (osc_q == cam_pkg::CAM_OSC_SYNCED);
    event_d[cam_pkg::ALM_CLK_UPSET]  = clk_mismatch_q || powerdown_exit_in;
  end

  always_comb begin
    clear_d = '0;
    if (wr_en && paddr_in == cam_pkg::OFF_STATUS) begin
      clear_d = pwdata_in[cam_pkg::ALM_W-1:0];
    end
    alarm_status_bits_d = (alarm_status_bits_q & ~clear_d) | event_d;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      alarm_status_bits_q <= cam_pkg::STATUS_RST;
    end else begin
      alarm_status_bits_q <= alarm_status_bits_d;
    end
  end

  assign summary_d = |(alarm_status_bits_d & ~alarm_mask_q);

  // ==========================================================
  // control registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      alarm_mask_q <= cam_pkg::MASK_RST;
      irq_mask_q   <= cam_pkg::IRQ_MASK_RST;
      config_q     <= cam_pkg::CONFIG_RST;
    end else if (wr_en) begin
      case (paddr_in)
        cam_pkg::OFF_MASK: begin
          alarm_mask_q <= pwdata_in[cam_pkg::ALM_W-1:0];
        end
        cam_pkg::OFF_IRQ_MASK: begin
          irq_mask_q <= pwdata_in[cam_pkg::ALM_W-1:0];
        end
        cam_pkg::OFF_CONFIG: begin
          config_q <= pwdata_in[cam_pkg::CFG_W-1:0];
        end
        default: begin
          config_q <= config_q;
        end
      endcase
    end
  end

  // ==========================================================
  // outputs; registered from next status so they change with status and both come from flops
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      calibration_status_pin_out <= 1'b0;
      irq_out                    <= 1'b0;
    end else begin
      calibration_status_pin_out <= config_q[cam_pkg::CFG_PIN_ALARM] && summary_d;
      irq_out                    <= |(alarm_status_bits_d & irq_mask_q);
    end
  end

  // ==========================================================
  // apb: zero wait states, read data latched in setup
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && (paddr_in > cam_pkg::OFF_LIVE || paddr_in[1:0] != 2'h0);
      if (rd_en) begin
        case (paddr_in)
          cam_pkg::OFF_STATUS:   prdata_out <= {27'h0, alarm_status_bits_q};
          cam_pkg::OFF_MASK:     prdata_out <= {27'h0, alarm_mask_q};
          cam_pkg::OFF_SUMMARY:  prdata_out <= {31'h0, |(alarm_status_bits_q & ~alarm_mask_q)};
          cam_pkg::OFF_CONFIG:   prdata_out <= {30'h0, config_q};
          cam_pkg::OFF_IRQ_MASK: prdata_out <= {27'h0, irq_mask_q};
          cam_pkg::OFF_LIVE:     prdata_out <= {30'h0, osc_q};
          default:               prdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // checks
  // clear_d carries the decoded clearing write of this cycle
  sticky_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    alarm_status_bits_q[0] && !clear_d[0] |=> alarm_status_bits_q[0])
    else $error("status bit dropped without clear");

  set_wins_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    clear_d[1] && !link_data_state_in |=> alarm_status_bits_q[1])
    else $error("event lost under clear");

  clear_works_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    clear_d[2] && !realign_pulse_in |=> !alarm_status_bits_q[2])
    else $error("clear write ignored");

  pll_alarm_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !pll_locked_in |=> alarm_status_bits_q[0])
    else $error("pll unlock not flagged");

  osc_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    osc_q == cam_pkg::CAM_OSC_UNSYNCED && !alarm_status_bits_q[3] && !event_d[3] |=> !alarm_status_bits_q[3])
    else $error("oscillator flag set before sync");

  // ==========================================================
  // multi-step upset paths; compare stage adds one cycle
  sequence osc_mismatch_s;
    osc_q == cam_pkg::CAM_OSC_SYNCED && !powerdown_exit_in && phase_acc_a_in != phase_acc_b_in;
  endsequence

  sequence osc_kept_s;
    osc_q == cam_pkg::CAM_OSC_SYNCED;
  endsequence

  sequence clk_mismatch_s;
    half_rate_tick_in && clocks_a_in != clocks_b_in;
  endsequence

  osc_upset_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    osc_mismatch_s ##1 osc_kept_s |=> alarm_status_bits_q[3])
    else $error("phase mismatch missed");

  clk_upset_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    clk_mismatch_s |-> ##2 alarm_status_bits_q[4])
    else $error("clock mismatch missed");

  pin_follow_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $past(config_q[0]) && $past(summary_d) |-> calibration_status_pin_out)
    else $error("status pin not driven on alarm");

  masked_quiet_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    alarm_mask_q == 5'h1f |=> !calibration_status_pin_out)
    else $error("masked alarm reached pin");

  // ==========================================================
  // alarm sources and sync tracker
  link_alarm_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !link_data_state_in |=> alarm_status_bits_q[1])
    else $error("link idle not flagged");

  realign_alarm_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    realign_pulse_in |=> alarm_status_bits_q[2])
    else $error("realign not flagged");

  pd_clk_alarm_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    powerdown_exit_in |=> alarm_status_bits_q[4])
    else $error("powerdown exit not flagged");

  clk_quiet_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !(half_rate_tick_in && clocks_a_in != clocks_b_in) |=> !clk_mismatch_q)
    else $error("clock mismatch without cause");

  osc_sync_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    osc_q == cam_pkg::CAM_OSC_UNSYNCED && sync_evt |=> osc_q == cam_pkg::CAM_OSC_SYNCED)
    else $error("sync event ignored");

  osc_drop_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    osc_q == cam_pkg::CAM_OSC_SYNCED && powerdown_exit_in |=> osc_q == cam_pkg::CAM_OSC_UNSYNCED)
    else $error("sync kept over powerdown");

  status_quiet_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    event_d == '0 && clear_d == '0 |=> alarm_status_bits_q == $past(alarm_status_bits_q))
    else $error("status moved without cause");

  // ==========================================================
  // pin and interrupt
  pin_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !config_q[cam_pkg::CFG_PIN_ALARM] |=> !calibration_status_pin_out)
    else $error("pin driven while unselected");

  pin_quiet_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !summary_d |=> !calibration_status_pin_out)
    else $error("pin high without alarm");

  irq_follow_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    |(alarm_status_bits_d & irq_mask_q) |=> irq_out)
    else $error("interrupt not raised");

  irq_quiet_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !(|(alarm_status_bits_d & irq_mask_q)) |=> !irq_out)
    else $error("interrupt without cause");

  // ==========================================================
  // register bus
  pready_setup_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    psel_in && !penable_in |=> pready_out)
    else $error("no ready after setup");

  pready_pulse_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    pready_out |=> !pready_out)
    else $error("ready held too long");

  slverr_ready_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    pslverr_out |-> pready_out)
    else $error("error without ready");

  mask_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_en && paddr_in == cam_pkg::OFF_MASK |=> alarm_mask_q == $past(pwdata_in[4:0]))
    else $error("mask write lost");

  irqmask_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_en && paddr_in == cam_pkg::OFF_IRQ_MASK |=> irq_mask_q == $past(pwdata_in[4:0]))
    else $error("irq mask write lost");

  config_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_en && paddr_in == cam_pkg::OFF_CONFIG |=> config_q == $past(pwdata_in[1:0]))
    else $error("config write lost");

endmodule
